// [rtl/bmm_pkg.sv]
// constants and carrier types for the bypass and mute input monitor
package bmm_pkg;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned CROSS_SHORT_MS = 2000;
  localparam int unsigned SIMUL_MS = 3000;
  localparam int unsigned DEBOUNCE_MS = 6;
  localparam int unsigned CROSS_SHORT_CYC = CROSS_SHORT_MS * (CLK_HZ / 1000);
  localparam int unsigned SIMUL_CYC = SIMUL_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYC = DEBOUNCE_MS * (CLK_HZ / 1000);
  localparam int unsigned PULSE_PERIOD_CYC = 2000;
  localparam int unsigned PULSE_SETTLE_CYC = 20;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [2:0] {
    BMM_DUAL_2T,
    BMM_DUAL_3T,
    BMM_DUAL_4T,
    BMM_DUAL_PNP,
    BMM_COMP_CONTACT,
    BMM_COMP_PNP
  } bmm_wiring_e;

  typedef enum logic [1:0] {
    BMM_MS_IDLE,
    BMM_MS_WAIT,
    BMM_MS_MUTED,
    BMM_MS_BLOCK
  } bmm_mute_e;

  typedef struct packed {
    logic chan_a;
    logic chan_b;
  } bmm_pair_s;
endpackage

// [rtl/bmm_monitor.sv]
// bypass key switch and muting sensor pair input monitor
`timescale 1ns/1ps
module bmm_monitor #(
  parameter int unsigned CROSS_SHORT_CYC = bmm_pkg::CROSS_SHORT_CYC,
  parameter int unsigned SIMUL_CYC = bmm_pkg::SIMUL_CYC,
  parameter int unsigned DEBOUNCE_CYC = bmm_pkg::DEBOUNCE_CYC,
  parameter int unsigned PULSE_PERIOD_CYC = bmm_pkg::PULSE_PERIOD_CYC
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // configuration
  input wire bmm_pkg::bmm_wiring_e wiring_i,
  input wire logic directional_i,
  // bypass key switch channels (1 = contact closed / conducting)
  input wire bmm_pkg::bmm_pair_s bypass_pins_i,
  // muting sensor pairs
  input wire bmm_pkg::bmm_pair_s mute_pair1_i,
  input wire bmm_pkg::bmm_pair_s mute_pair2_i,
  input wire logic mute_permit_input_i,
  // safeguard, emergency stop, operator
  input wire logic safeguard_run_i,
  input wire logic estop_run_i,
  input wire logic start_i,
  input wire logic fault_clear_i,
  // test pulse drive for three/four-terminal wiring
  output logic test_pulse_a_o,
  output logic test_pulse_b_o,
  // results
  output logic run_o,
  output logic bypassed_o,
  output logic muted_o,
  output logic bypass_fault_o,
  output logic mute_fault_o
);
  localparam int unsigned SYNC_W = 9;

  typedef struct packed {
    logic [SYNC_W-1:0] stable;
    logic [1:0] bp_deb;
    logic [bmm_pkg::CNT_W-1:0] deb_cnt;
    logic [bmm_pkg::CNT_W-1:0] arm_cnt;
    logic armed;
    logic [bmm_pkg::CNT_W-1:0] open_cnt;
    logic [bmm_pkg::CNT_W-1:0] pulse_cnt;
    logic [bmm_pkg::CNT_W-1:0] sim_cnt;
    logic pulse_a;
    logic pulse_b;
    bmm_pkg::bmm_mute_e mstate;
    logic bp_fault;
    logic mu_fault;
    logic run;
    logic bypassed;
    logic muted;
  } bmm_state_s;

  bmm_state_s st, next_st;
  logic [SYNC_W-1:0] raw;

  assign raw = {mute_permit_input_i, safeguard_run_i, estop_run_i, start_i, fault_clear_i,
                mute_pair2_i.chan_b, mute_pair2_i.chan_a, mute_pair1_i.chan_b, mute_pair1_i.chan_a};

  // bypass channels get their own three stages below
  logic [1:0] bp_s0, bp_s1, bp_s2, bp_stable;
  logic [SYNC_W-1:0] in_s0, in_s1, in_s2;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bp_s0 <= 2'h0;
      bp_s1 <= 2'h0;
      bp_s2 <= 2'h0;
      bp_stable <= 2'h0;
      in_s0 <= '0;
      in_s1 <= '0;
      in_s2 <= '0;
    end else begin
      bp_s0 <= {bypass_pins_i.chan_b, bypass_pins_i.chan_a};
      bp_s1 <= bp_s0;
      bp_s2 <= bp_s1;
      for (int i = 0; i < 2; i++) begin
        if (bp_s1[i] == bp_s2[i]) begin
          bp_stable[i] <= bp_s2[i];
        end
      end
      in_s0 <= raw;
      in_s1 <= in_s0;
      in_s2 <= in_s1;
    end
  end
  // a change counts once the second and third stages agree
  logic [SYNC_W-1:0] in_ok;
  always_comb begin
    for (int i = 0; i < SYNC_W; i++) begin
      in_ok[i] = (in_s1[i] == in_s2[i]) ? in_s2[i] : st.stable[i];
    end
  end

  logic m1a, m1b, m2a, m2b, clr, strt, estop_ok, guard_ok, permit;
  assign m1a = in_ok[0];
  assign m1b = in_ok[1];
  assign m2a = in_ok[2];
  assign m2b = in_ok[3];
  assign clr = in_ok[4];
  assign strt = in_ok[5];
  assign estop_ok = in_ok[6];
  assign guard_ok = in_ok[7];
  assign permit = in_ok[8];

  logic comp_mode, pulse_mode, cross_mode;
  logic pair1_on, pair2_on, any1, any2, strt_rise;
  assign comp_mode = (wiring_i == bmm_pkg::BMM_COMP_CONTACT) || (wiring_i == bmm_pkg::BMM_COMP_PNP);
  assign pulse_mode = (wiring_i == bmm_pkg::BMM_DUAL_3T) || (wiring_i == bmm_pkg::BMM_DUAL_4T);
  assign cross_mode = (wiring_i == bmm_pkg::BMM_DUAL_2T) || (wiring_i == bmm_pkg::BMM_DUAL_3T);
  assign pair1_on = m1a && m1b;
  assign pair2_on = m2a && m2b;
  assign any1 = m1a || m1b;
  assign any2 = m2a || m2b;
  assign strt_rise = strt && !st.stable[5];

  always_comb begin
    logic bp_on;
    logic bp_bad;
    logic foreign;
    logic [1:0] dv;
    next_st = st;
    bp_on = 1'b0;
    bp_bad = 1'b0;
    foreign = 1'b0;
    next_st.stable = in_ok;
    dv = st.bp_deb;
    // complementary short across the closed contact shows only after debounce
    if (bp_stable != st.bp_deb) begin
      next_st.deb_cnt = st.deb_cnt + 1'b1;
      next_st.arm_cnt = '0;
      if (st.deb_cnt >= DEBOUNCE_CYC - 1) begin
        dv = bp_stable;
        next_st.bp_deb = bp_stable;
        next_st.deb_cnt = '0;
        next_st.armed = 1'b1;
      end
    end else begin
      next_st.deb_cnt = '0;
      // reset value 00 is no real reading; arm once a value held a full window
      next_st.arm_cnt = st.armed ? st.arm_cnt : st.arm_cnt + 1'b1;
      if (st.arm_cnt >= DEBOUNCE_CYC - 1) begin
        next_st.armed = 1'b1;
      end
    end
    // test pulses: each channel is briefly driven low in turn
    next_st.pulse_cnt = (st.pulse_cnt >= PULSE_PERIOD_CYC - 1) ? '0 : st.pulse_cnt + 1'b1;
    next_st.pulse_a = pulse_mode && (st.pulse_cnt < bmm_pkg::PULSE_SETTLE_CYC);
    next_st.pulse_b = pulse_mode && (st.pulse_cnt >= PULSE_PERIOD_CYC / 2)
                      && (st.pulse_cnt < PULSE_PERIOD_CYC / 2 + bmm_pkg::PULSE_SETTLE_CYC);
    // a channel still high at the end of its own pulse is fed from elsewhere
    if (pulse_mode && st.pulse_cnt == bmm_pkg::PULSE_SETTLE_CYC - 1 && bp_stable[0]) begin
      foreign = 1'b1;
    end
    if (pulse_mode && st.pulse_cnt == PULSE_PERIOD_CYC / 2 + bmm_pkg::PULSE_SETTLE_CYC - 1 && bp_stable[1]) begin
      foreign = 1'b1;
    end
    // pulse on one channel seen on the other means cross short
    if (wiring_i == bmm_pkg::BMM_DUAL_4T && st.pulse_a && st.pulse_cnt == bmm_pkg::PULSE_SETTLE_CYC - 1
        && !bp_stable[1] && !bp_stable[0] && st.bp_deb == 2'h3) begin
      foreign = 1'b1;
    end
    // cross short shows as both open for over 2 s without chan mismatch
    if (cross_mode && dv == 2'h0) begin
      next_st.open_cnt = (st.open_cnt >= CROSS_SHORT_CYC) ? st.open_cnt : st.open_cnt + 1'b1;
    end else begin
      next_st.open_cnt = '0;
    end
    if (cross_mode && st.open_cnt >= CROSS_SHORT_CYC) begin
      bp_bad = 1'b1;
    end
    // complementary channels must differ, equal means shorted
    if (comp_mode && st.armed && dv[0] == dv[1]) begin
      bp_bad = 1'b1;
    end
    // sourcing dual wiring: no short detection in this block
    if (wiring_i == bmm_pkg::BMM_DUAL_PNP) begin
      foreign = 1'b0;
    end
    if (comp_mode) begin
      bp_on = dv[1] && !dv[0];
    end else begin
      bp_on = dv[0] && dv[1];
    end
    // fault latches and holds input in stop state, set wins over clear
    if (clr && !bp_bad && !foreign) begin
      next_st.bp_fault = 1'b0;
    end
    if (bp_bad || foreign) begin
      next_st.bp_fault = 1'b1;
    end
    next_st.bypassed = bp_on && !next_st.bp_fault;

    // mute sequencing, each sensor monitored separately
    next_st.sim_cnt = '0;
    case (st.mstate)
      bmm_pkg::BMM_MS_IDLE: begin
        if (permit && (any1 || any2) && !st.mu_fault) begin
          if (directional_i && any2 && !pair1_on) begin
            next_st.mstate = bmm_pkg::BMM_MS_BLOCK;
          end else if (pair1_on) begin
            next_st.mstate = bmm_pkg::BMM_MS_MUTED;
          end else if (!directional_i && pair2_on) begin
            next_st.mstate = bmm_pkg::BMM_MS_MUTED;
          end else begin
            next_st.mstate = bmm_pkg::BMM_MS_WAIT;
          end
        end
      end
      bmm_pkg::BMM_MS_WAIT: begin
        next_st.sim_cnt = st.sim_cnt + 1'b1;
        if (directional_i && any2 && !pair1_on) begin
          next_st.mstate = bmm_pkg::BMM_MS_BLOCK;
        end else if (permit && (pair1_on || (!directional_i && pair2_on))) begin
          next_st.mstate = bmm_pkg::BMM_MS_MUTED;
        end else if (!any1 && !any2) begin
          next_st.mstate = bmm_pkg::BMM_MS_IDLE;
        end else if (st.sim_cnt >= SIMUL_CYC - 1) begin
          next_st.mstate = bmm_pkg::BMM_MS_BLOCK;
          next_st.mu_fault = 1'b1;
        end
      end
      bmm_pkg::BMM_MS_MUTED: begin
        // permit ignored once muted
        if (!pair1_on && !pair2_on) begin
          next_st.mstate = bmm_pkg::BMM_MS_IDLE;
        end
      end
      bmm_pkg::BMM_MS_BLOCK: begin
        if (!any1 && !any2) begin
          next_st.mstate = bmm_pkg::BMM_MS_IDLE;
        end
      end
      default: begin
        next_st.mstate = bmm_pkg::BMM_MS_IDLE;
      end
    endcase
    if (clr && st.mstate != bmm_pkg::BMM_MS_WAIT && !(st.mstate == bmm_pkg::BMM_MS_WAIT
        && st.sim_cnt >= SIMUL_CYC - 1)) begin
      next_st.mu_fault = 1'b0;
    end
    next_st.muted = (next_st.mstate == bmm_pkg::BMM_MS_MUTED);

    // run: estop always acts, safeguard ignored while muted or bypassed
    if (!estop_ok || next_st.bp_fault || next_st.mu_fault) begin
      next_st.run = 1'b0;
    end else if (!guard_ok && !next_st.muted && !next_st.bypassed) begin
      next_st.run = 1'b0;
    end else if (strt_rise) begin
      next_st.run = 1'b1; // restart only by a fresh start edge
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign test_pulse_a_o = st.pulse_a;
  assign test_pulse_b_o = st.pulse_b;
  assign run_o = st.run;
  assign bypassed_o = st.bypassed;
  assign muted_o = st.muted;
  assign bypass_fault_o = st.bp_fault;
  assign mute_fault_o = st.mu_fault;
endmodule

// [testbench/bmm_field_model.sv]
// field model of the bypass key switch with injectable wiring faults
`timescale 1ns/1ps
module bmm_field_model (
  // test pulses from the monitor
  input wire logic test_pulse_a_i,
  input wire logic test_pulse_b_i,
  // switch state and injected faults
  input wire bmm_pkg::bmm_wiring_e wiring_i,
  input wire logic key_on_i,
  input wire logic supply_short_i,
  input wire logic cross_short_i,
  // contact levels, open reads low through the pull-down
  output wire bmm_pkg::bmm_pair_s pins_o
);
  logic comp;
  logic a_raw;
  logic b_raw;
  assign comp = wiring_i inside {bmm_pkg::BMM_COMP_CONTACT, bmm_pkg::BMM_COMP_PNP};
  // a foreign supply holds channel a up through its own test pulse
  assign a_raw = ((comp ? !key_on_i : key_on_i) && !test_pulse_a_i) || supply_short_i;
  assign b_raw = key_on_i && !test_pulse_b_i;
  // shorted channels share one wire, either side pulls it low
  assign pins_o.chan_a = cross_short_i ? (a_raw && b_raw) : a_raw;
  assign pins_o.chan_b = cross_short_i ? (a_raw && b_raw) : b_raw;
endmodule

// [testbench/bmm_monitor_props.sv]
// property checker for the bypass and mute input monitor
`timescale 1ns/1ps
module bmm_monitor_props (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // watched inputs
  input wire bmm_pkg::bmm_pair_s mute_pair1_i,
  input wire bmm_pkg::bmm_pair_s mute_pair2_i,
  input wire logic mute_permit_input_i,
  input wire logic estop_run_i,
  input wire logic start_i,
  input wire logic fault_clear_i,
  // watched outputs
  input wire logic run_o,
  input wire logic muted_o,
  input wire logic bypass_fault_o,
  input wire logic mute_fault_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // ages saturate so an old cause never counts as recent
  logic [3:0] age_start;
  logic [3:0] age_permit;
  logic [3:0] age_pair;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      age_start <= 4'hF;
      age_permit <= 4'hF;
      age_pair <= 4'hF;
    end else begin
      age_start <= start_i ? 4'h0 : age_start + 4'(age_start != 4'hF);
      age_permit <= mute_permit_input_i ? 4'h0 : age_permit + 4'(age_permit != 4'hF);
      age_pair <= (&mute_pair1_i || &mute_pair2_i) ? 4'h0 : age_pair + 4'(age_pair != 4'hF);
    end
  end
  sequence no_clear;
    !fault_clear_i [*5];
  endsequence
  sequence muted_ok;
    muted_o && estop_run_i && !bypass_fault_o && !mute_fault_o;
  endsequence
  AST_ESTOP_STOPS: assert property (!estop_run_i [*4] |-> ##[0:4] !run_o)
    else $error("run kept with estop open");
  AST_RUN_NEEDS_START: assert property ($rose(run_o) |-> age_start < 4'h8)
    else $error("run rose without start");
  AST_RUN_NO_FAULT: assert property ($rose(run_o) |-> !bypass_fault_o && !mute_fault_o)
    else $error("run rose with a fault");
  AST_MUTE_PERMIT: assert property ($rose(muted_o) |-> age_permit < 4'h8)
    else $error("mute began without permit");
  AST_MUTE_PAIR: assert property ($rose(muted_o) |-> age_pair < 4'h8)
    else $error("mute began without a full pair");
  AST_MUTE_HOLDS_RUN: assert property (run_o ##0 muted_ok ##1 muted_ok [*6] |-> run_o)
    else $error("run dropped while muted");
  AST_BYP_FAULT_LATCH: assert property (no_clear ##0 bypass_fault_o |=> bypass_fault_o)
    else $error("bypass fault dropped");
  AST_MUTE_FAULT_LATCH: assert property (no_clear ##0 mute_fault_o |=> mute_fault_o)
    else $error("mute fault dropped");
endmodule
bind bmm_monitor bmm_monitor_props i_props (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .mute_pair1_i(mute_pair1_i),
  .mute_pair2_i(mute_pair2_i),
  .mute_permit_input_i(mute_permit_input_i),
  .estop_run_i(estop_run_i),
  .start_i(start_i),
  .fault_clear_i(fault_clear_i),
  .run_o(run_o),
  .muted_o(muted_o),
  .bypass_fault_o(bypass_fault_o),
  .mute_fault_o(mute_fault_o)
);

// [testbench/bypass_and_mute_input_monitor_tb_top.sv]
// self-checking bench for the bypass and mute input monitor
`timescale 1ns/1ps
module bypass_and_mute_input_monitor_tb_top;
  logic clk = 1'h0;
  logic rst = 1'h1;
  bmm_pkg::bmm_wiring_e w = bmm_pkg::BMM_DUAL_4T;
  bmm_pkg::bmm_pair_s pins;
  // one bit per sensor, no shared source
  bmm_pkg::bmm_pair_s m1 = 2'h0;
  bmm_pkg::bmm_pair_s m2 = 2'h0;
  logic dir = 1'h0, pmt = 1'h1, grd = 1'h1, est = 1'h1, sta = 1'h0, clr = 1'h0;
  logic key = 1'h0, ss = 1'h0, xs = 1'h0;
  logic tpa, tpb, run, byp, mut, bf, mf;
  int miscompares = 0;
  int checks = 0;
  // debounce outlasts one test pulse but not the gap between two
  localparam int unsigned PERIOD = 200;
  bmm_monitor #(.CROSS_SHORT_CYC(200), .SIMUL_CYC(300), .DEBOUNCE_CYC(25), .PULSE_PERIOD_CYC(PERIOD)) i_dut (
    .clk_i(clk), .rst_i(rst), .wiring_i(w), .directional_i(dir), .bypass_pins_i(pins),
    .mute_pair1_i(m1), .mute_pair2_i(m2), .mute_permit_input_i(pmt), .safeguard_run_i(grd),
    .estop_run_i(est), .start_i(sta), .fault_clear_i(clr), .test_pulse_a_o(tpa), .test_pulse_b_o(tpb),
    .run_o(run), .bypassed_o(byp), .muted_o(mut), .bypass_fault_o(bf), .mute_fault_o(mf));
  bmm_field_model i_field (.test_pulse_a_i(tpa), .test_pulse_b_i(tpb), .wiring_i(w), .key_on_i(key),
    .supply_short_i(ss), .cross_short_i(xs), .pins_o(pins));
  initial forever #25 clk = ~clk;
  task automatic chk(input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic reboot(input bmm_pkg::bmm_wiring_e wir);
    rst = 1'h1;
    w = wir;
    {m1, m2, dir, sta, clr, key, ss, xs} = 10'h000;
    {pmt, grd, est} = 3'h7;
    wt(2);
    rst = 1'h0;
    wt(2);
  endtask
  task automatic go;
    sta = 1'h1;
    wt(6);
    sta = 1'h0;
    wt(6);
  endtask
  task automatic t_mute;
    reboot(bmm_pkg::BMM_DUAL_4T);
    go();
    chk(run, 1'h1);
    m1 = 2'h3;
    wt(10);
    chk(mut, 1'h1);
    {grd, pmt} = 2'h0;
    wt(10);
    chk(run, 1'h1);
    chk(mut, 1'h1);
    m1 = 2'h0;
    wt(10);
    chk(run, 1'h0);
    grd = 1'h1;
    wt(10);
    chk(run, 1'h0);
  endtask
  task automatic t_refuse;
    reboot(bmm_pkg::BMM_DUAL_4T);
    pmt = 1'h0;
    m1 = 2'h3;
    wt(10);
    chk(mut, 1'h0);
    {m1, pmt, dir} = 4'h3;
    wt(10);
    m2 = 2'h3;
    wt(10);
    m1 = 2'h3;
    wt(10);
    chk(mut, 1'h0);
    {m1, m2} = 4'h0;
    wt(10);
    m1 = 2'h3;
    wt(10);
    chk(mut, 1'h1);
  endtask
  task automatic t_simul(input int gap, input logic e);
    m1.chan_a = 1'h1;
    wt(gap);
    m1.chan_b = 1'h1;
    wt(10);
    chk(mut, !e);
    chk(mf, e);
    m1 = 2'h0;
    clr = 1'h1;
    wt(10);
    clr = 1'h0;
    wt(10);
  endtask
  task automatic t_bypass;
    reboot(bmm_pkg::BMM_DUAL_4T);
    go();
    key = 1'h1;
    wt(120);
    chk(byp, 1'h1);
    // guard opens only once the bypass has settled through debounce
    grd = 1'h0;
    wt(10);
    chk(byp, 1'h1);
    chk(run, 1'h1);
    est = 1'h0;
    wt(10);
    chk(run, 1'h0);
  endtask
  task automatic t_fault(input bmm_pkg::bmm_wiring_e wir, input logic k, s, x, e);
    int unsigned na;
    int unsigned nb;
    int unsigned pc;
    reboot(wir);
    {key, ss, xs} = {k, s, x};
    na = 0;
    nb = 0;
    pc = (wir == bmm_pkg::BMM_DUAL_3T || wir == bmm_pkg::BMM_DUAL_4T) ? bmm_pkg::PULSE_SETTLE_CYC : 0;
    wt(100);
    // one full pulse period holds exactly one pulse per channel in three/four-terminal wiring, none in the others
    repeat (PERIOD) begin
      @(negedge clk);
      na += tpa;
      nb += tpb;
    end
    chk(bf, e);
    chk(byp, k & !e);
    chk(na == pc, 1'h1);
    chk(nb == pc, 1'h1);
  endtask
  task automatic finish_test;
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    t_mute();
    t_refuse();
    reboot(bmm_pkg::BMM_DUAL_4T);
    t_simul(320, 1'h1);
    t_simul(280, 1'h0);
    t_bypass();
    t_fault(bmm_pkg::BMM_DUAL_3T, 1'h1, 1'h1, 1'h0, 1'h1);
    t_fault(bmm_pkg::BMM_DUAL_2T, 1'h0, 1'h0, 1'h0, 1'h1);
    t_fault(bmm_pkg::BMM_DUAL_PNP, 1'h1, 1'h1, 1'h0, 1'h0);
    t_fault(bmm_pkg::BMM_DUAL_4T, 1'h1, 1'h1, 1'h0, 1'h1);
    t_fault(bmm_pkg::BMM_DUAL_4T, 1'h1, 1'h0, 1'h1, 1'h1);
    t_fault(bmm_pkg::BMM_DUAL_4T, 1'h1, 1'h0, 1'h0, 1'h0);
    t_fault(bmm_pkg::BMM_COMP_CONTACT, 1'h1, 1'h0, 1'h0, 1'h0);
    t_fault(bmm_pkg::BMM_COMP_CONTACT, 1'h0, 1'h0, 1'h1, 1'h1);
    t_fault(bmm_pkg::BMM_COMP_PNP, 1'h0, 1'h0, 1'h1, 1'h1);
    finish_test();
  end
  initial begin
    #1000000;
    miscompares++;
    finish_test();
  end
endmodule
